// ---- logic/cifd_decoder.sv ----
// compact instruction field decoder: halfword unpacking, minor-field decode,
// reserved detection and the two-operand word add writeback
// assumes fetchData is an aligned 32-bit element; rfRdData is a combinational
// read of rfRdIdx from the integer register file
`timescale 1ns/10ps
module cifd_decoder
  import cifd_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // fetch side
  input  wire logic              fetchValid,
  input  wire logic [WORD_W-1:0] fetchData,
  input  wire logic              fetchSkipFirst,
  input  wire logic              fetchUncached,
  input  wire logic              bigEndian,
  output logic                   fetchReady,
  output logic                   fetchWide,
  // decode out
  output logic                   decValid,
  output cifd_dec_t              decInfo,
  output logic                   rsvdExc,
  // register file
  output logic      [REG_W-1:0]  rfRdIdx,
  input  wire logic [DW_W-1:0]   rfRdData,
  output logic                   rfWrEn,
  output logic      [REG_W-1:0]  rfWrIdx,
  output logic      [DW_W-1:0]   rfWrData
);

  logic [HW_W-1:0]   hwFirst_ff;
  logic [HW_W-1:0]   hwSecond_ff;
  logic [1:0]        hwLeft_ff;
  logic              hwValid;
  logic [HW_W-1:0]   hw;
  logic [4:0]        major;
  logic [HW_W-1:0]   pfx_ff;
  logic              pendPfx_ff;
  logic              isExt;
  logic              twoHalf;
  logic              fire;
  logic              nonExt;
  logic [REG_W-1:0]  rxPhys;
  logic [REG_W-1:0]  ryPhys;
  cifd_dec_t         nxtDec;
  logic              nxtRsvd;
  cifd_dec_t         dec_ff;
  logic              decValid_ff;
  logic              rsvd_ff;
  logic              execPend_ff;
  logic [IMM8_W-1:0] execImm_ff;
  logic [REG_W-1:0]  rfRdIdx_ff;
  logic              rfWrEn_ff;
  logic [REG_W-1:0]  rfWrIdx_ff;
  logic [DW_W-1:0]   rfWrData_ff;
  logic [WORD_W-1:0] sum;

  // one aligned word per fetch, never a double-word burst when uncached
  assign fetchWide  = !fetchUncached;
  // refill as the last held halfword leaves, so the stream has no bubble
  assign fetchReady = (hwLeft_ff <= 2'h1);
  assign hwValid    = (hwLeft_ff != RST_HW_LEFT);
  assign hw         = hwFirst_ff;
  assign major      = hw[MAJ_LSB +: 5];

  // lower address halfword leaves first in either endian
  always_ff @(posedge clk) begin
    if (rst) begin
      hwLeft_ff   <= RST_HW_LEFT;
      hwFirst_ff  <= '0;
      hwSecond_ff <= '0;
    end else if (fetchValid && fetchReady) begin
      if (fetchSkipFirst) begin
        hwFirst_ff <= bigEndian ? fetchData[HW_W-1:0] : fetchData[WORD_W-1:HW_W];
        hwLeft_ff  <= 2'h1;
      end else begin
        hwFirst_ff  <= bigEndian ? fetchData[WORD_W-1:HW_W] : fetchData[HW_W-1:0];
        hwSecond_ff <= bigEndian ? fetchData[HW_W-1:0] : fetchData[WORD_W-1:HW_W];
        hwLeft_ff   <= 2'h2;
      end
    end else if (hwValid) begin
      hwFirst_ff <= hwSecond_ff;
      hwLeft_ff  <= hwLeft_ff - 2'h1;
    end
  end

  // two-halfword forms wait for their second half from the same stream
  assign twoHalf = (major == MAJ_EXTEND) || (major == MAJ_LINK_FORM);
  assign isExt   = pendPfx_ff && (pfx_ff[MAJ_LSB +: 5] == MAJ_EXTEND);
  assign fire    = hwValid && (pendPfx_ff || !twoHalf);

  always_ff @(posedge clk) begin
    if (rst) begin
      pendPfx_ff <= 1'b0;
      pfx_ff     <= '0;
    end else if (hwValid) begin
      pendPfx_ff <= !pendPfx_ff && twoHalf;
      if (!pendPfx_ff) begin
        pfx_ff <= hw;
      end
    end
  end

  cifd_reg_xlat uRxXlat (
    .fld (hw[RX_LSB +: FLD_W]),
    .idx (rxPhys)
  );

  cifd_reg_xlat uRyXlat (
    .fld (hw[RY_LSB +: FLD_W]),
    .idx (ryPhys)
  );

  // in the imm8 class only the two full-register moves (101, 111) refuse a prefix
  assign nonExt = (major == MAJ_LINK_FORM) || (major == MAJ_EXTEND) || (major == MAJ_THREE)
                  || (major == MAJ_REGREG)
                  || ((major == MAJ_IMM8) && hw[RX_LSB] && hw[RX_LSB+2]);

  always_comb begin
    nxtDec          = '0;
    nxtDec.op       = OP_OTHER;
    nxtDec.rx       = rxPhys;
    nxtDec.ry       = ryPhys;
    nxtDec.extended = isExt;
    nxtRsvd         = 1'b0;
    if (pendPfx_ff && !isExt) begin
      nxtDec.op = pfx_ff[ISA_SWITCH_BIT] ? OP_JUMP_LINK_ISA_SWITCH : OP_JUMP_AND_LINK;
    end else begin
      case (major)
        MAJ_SHIFT: begin
          case (hw[1:0])
            2'h0: nxtDec.op = OP_SHIFT_LEFT_LOGICAL;
            2'h1: begin
              nxtDec.op        = OP_DWORD_SHIFT_LEFT;
              nxtDec.dwordOnly = 1'b1;
            end
            2'h2: nxtDec.op = OP_SHIFT_RIGHT_LOGICAL;
            default: nxtDec.op = OP_SHIFT_RIGHT_ARITH;
          endcase
        end
        MAJ_RIA: begin
          nxtDec.op        = hw[RIA_BIT] ? OP_DWORD_ADD_IMM : OP_ADD_IMM_WORD3;
          nxtDec.dwordOnly = hw[RIA_BIT];
        end
        MAJ_ADDI8: nxtDec.op = OP_ADD_IMM_WORD;
        MAJ_IMM8: begin
          case (hw[RX_LSB +: FLD_W])
            3'h0: nxtDec.op = OP_BRANCH_T_ZERO;
            3'h1: nxtDec.op = OP_BRANCH_T_NONZERO;
            3'h2: nxtDec.op = OP_STORE_RA_SP;
            3'h3: nxtDec.op = OP_ADJUST_STACK_PTR;
            3'h4: nxtDec.op = hw[SAVE_BIT] ? OP_SAVE : OP_RESTORE;
            3'h5: nxtDec.op = OP_COPY_TO_FULL_REG;
            3'h7: nxtDec.op = OP_COPY_FROM_FULL_REG;
            default: nxtRsvd = 1'b1;
          endcase
        end
        MAJ_THREE: begin
          nxtDec.dwordOnly = !hw[0];
          case (hw[1:0])
            2'h0: nxtDec.op = OP_DWORD_ADD_UNSIGNED;
            2'h1: nxtDec.op = OP_ADD_UNSIGNED_WORD;
            2'h2: nxtDec.op = OP_DWORD_SUB_UNSIGNED;
            default: nxtDec.op = OP_SUB_UNSIGNED_WORD;
          endcase
        end
        MAJ_REGREG: begin
          case (hw[4:0])
            5'h00: begin
              case (hw[RY_LSB +: FLD_W])
                3'h0: nxtDec.op = OP_JUMP_REG_RX;
                3'h1: nxtDec.op = OP_JUMP_REG_RA;
                3'h2: nxtDec.op = OP_LINK_JUMP_REG;
                3'h4: nxtDec.op = OP_COMPACT_JUMP_REG_RX;
                3'h5: nxtDec.op = OP_COMPACT_JUMP_REG_RA;
                3'h6: nxtDec.op = OP_COMPACT_LINK_JUMP_REG;
                default: nxtRsvd = 1'b1;
              endcase
            end
            5'h01: nxtDec.op = OP_DEBUG_BREAKPOINT;
            5'h11: begin
              nxtDec.dwordOnly = (hw[RY_LSB +: 2] == 2'h2);
              case (hw[RY_LSB +: FLD_W])
                3'h0: nxtDec.op = OP_ZERO_EXT_BYTE;
                3'h1: nxtDec.op = OP_ZERO_EXT_HALF;
                3'h2: nxtDec.op = OP_ZERO_EXT_WORD;
                3'h4: nxtDec.op = OP_SIGN_EXT_BYTE;
                3'h5: nxtDec.op = OP_SIGN_EXT_HALF;
                3'h6: nxtDec.op = OP_SIGN_EXT_WORD;
                default: nxtRsvd = 1'b1;
              endcase
            end
            5'h18: nxtDec.op = OP_PRODUCT;
            5'h1A: nxtDec.op = OP_QUOTIENT;
            5'h09, 5'h15: nxtRsvd = 1'b1;
            default: begin
              nxtDec.op        = OP_REGREG_OTHER;
              nxtDec.dwordOnly = (hw[4:0] == 5'h08) || (hw[4:0] == 5'h13)
                                 || (hw[4:0] == 5'h14) || (hw[4:0] == 5'h16)
                                 || (hw[4:0] == 5'h17) || (hw[4:3] == 2'h3 && hw[2]);
            end
          endcase
        end
        MAJ_IMM64: begin
          nxtDec.dwordOnly = 1'b1;
          case (hw[RX_LSB +: FLD_W])
            3'h0: nxtDec.op = OP_LOAD_DWORD_STACK;
            3'h1: nxtDec.op = OP_STORE_DWORD_STACK;
            3'h2: nxtDec.op = OP_STORE_RA_DWORD_STACK;
            3'h3: nxtDec.op = OP_DWORD_ADJUST_STACK;
            3'h4: nxtDec.op = OP_LOAD_DWORD_PCREL;
            3'h5: nxtDec.op = OP_DWORD_ADD_IMM5;
            3'h6: nxtDec.op = OP_DWORD_ADD_IMM_PCREL;
            default: nxtDec.op = OP_DWORD_ADD_IMM_STACK;
          endcase
        end
        default: nxtDec.op = OP_OTHER;
      endcase
      if (isExt && nonExt) begin
        nxtRsvd = 1'b1;
      end
    end
    if (nxtRsvd) begin
      nxtDec.op        = OP_RESERVED;
      nxtDec.dwordOnly = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      decValid_ff <= 1'b0;
      rsvd_ff     <= 1'b0;
      dec_ff      <= '0;
    end else begin
      decValid_ff <= fire;
      rsvd_ff     <= fire && nxtRsvd;
      if (fire) begin
        dec_ff <= nxtDec;
      end
    end
  end

  // read issued with the decode; write one cycle later
  // limitation: back-to-back adds to one register need the file's bypass
  always_ff @(posedge clk) begin
    if (rst) begin
      execPend_ff <= 1'b0;
      execImm_ff  <= '0;
      rfRdIdx_ff  <= '0;
    end else begin
      execPend_ff <= fire && (nxtDec.op == OP_ADD_IMM_WORD) && !nxtDec.extended;
      if (fire) begin
        execImm_ff <= hw[IMM8_W-1:0];
        rfRdIdx_ff <= rxPhys;
      end
    end
  end

  // no overflow check: a non-word source just yields whatever the low half gives
  assign sum = rfRdData[WORD_W-1:0] + {{(WORD_W-IMM8_W){execImm_ff[IMM8_W-1]}}, execImm_ff};

  always_ff @(posedge clk) begin
    if (rst) begin
      rfWrEn_ff   <= 1'b0;
      rfWrIdx_ff  <= '0;
      rfWrData_ff <= '0;
    end else begin
      rfWrEn_ff <= execPend_ff;
      if (execPend_ff) begin
        rfWrIdx_ff  <= rfRdIdx_ff;
        rfWrData_ff <= {{(DW_W-WORD_W){sum[WORD_W-1]}}, sum};
      end
    end
  end

  assign decValid = decValid_ff;
  assign decInfo  = dec_ff;
  assign rsvdExc  = rsvd_ff;
  assign rfRdIdx  = rfRdIdx_ff;
  assign rfWrEn   = rfWrEn_ff;
  assign rfWrIdx  = rfWrIdx_ff;
  assign rfWrData = rfWrData_ff;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_big_order: assert property (
    fetchValid && fetchReady && bigEndian && !fetchSkipFirst
    |=> hwFirst_ff == $past(fetchData[31:16]) ##1 hwFirst_ff == $past(fetchData[15:0], 2)
  ) else $error("big-endian halfword order wrong");

  a_little_order: assert property (
    fetchValid && fetchReady && !bigEndian && !fetchSkipFirst
    |=> hwFirst_ff == $past(fetchData[15:0]) ##1 hwFirst_ff == $past(fetchData[31:16], 2)
  ) else $error("little-endian halfword order wrong");

  a_link_switch: assert property (
    hwValid && pendPfx_ff && !isExt
    |=> decValid_ff && (dec_ff.op == ($past(pfx_ff[10]) ? OP_JUMP_LINK_ISA_SWITCH
                                                      : OP_JUMP_AND_LINK))
  ) else $error("jump-and-link switch bit decoded wrong");

  a_shift_arith: assert property (
    decValid_ff && dec_ff.op == OP_SHIFT_RIGHT_ARITH |-> $past(hw[1:0]) == 2'h3
  ) else $error("arith shift from wrong minor field");

  a_imm8_unused: assert property (
    fire && major == MAJ_IMM8 && hw[10:8] == 3'h6 && !(pendPfx_ff && !isExt)
    |=> rsvdExc && decInfo.op == OP_RESERVED
  ) else $error("unassigned imm8 function not reserved");

  a_ext_nonext: assert property (
    hwValid && isExt && (major == MAJ_THREE || major == MAJ_REGREG) |=> rsvdExc
  ) else $error("extended non-extensible encoding not reserved");

  a_save_bit: assert property (
    decValid_ff && (dec_ff.op == OP_SAVE || dec_ff.op == OP_RESTORE)
    |-> $past(hw[7]) == (dec_ff.op == OP_SAVE)
  ) else $error("save/restore bit decoded wrong");

  a_xlat_rx: assert property (
    decValid_ff |-> dec_ff.rx == (($past(hw[10:8]) < 3'h2) ? {2'h2, $past(hw[10:8])}
                                                        : {2'h0, $past(hw[10:8])})
  ) else $error("rx translation wrong");

  a_add_writeback: assert property (
    decValid_ff && dec_ff.op == OP_ADD_IMM_WORD && !dec_ff.extended
    |=> rfWrEn && rfWrIdx == $past(dec_ff.rx)
  ) else $error("word add writeback missing");

  a_add_wrap: assert property (
    rfWrEn |-> rfWrData[31:0] == $past(rfRdData[31:0] + {{24{execImm_ff[7]}}, execImm_ff})
               && rfWrData[63:32] == {32{rfWrData[31]}}
  ) else $error("word add result not wrapped and sign-extended");

  c_extended_decode: cover property (decValid_ff && dec_ff.extended && !rsvdExc);
  c_link_pair:       cover property (decValid_ff && dec_ff.op == OP_JUMP_LINK_ISA_SWITCH);
  c_add_writeback:   cover property (rfWrEn ##1 rfWrEn);
  c_skip_first:      cover property (fetchValid && fetchReady && fetchSkipFirst);

endmodule : cifd_decoder

// ---- logic/cifd_pkg.sv ----
// constants, decode enumeration and carrier struct for the compact field decoder
// assumes one core clock; fetch path and register file sit outside the block
// Function
// - bit 26 of the two-halfword form picks plain or isa-switching jump-and-link
// - shift class minor bits 1..0: left, dword left, right logical, right arith
// - register-immediate add class bit 4: word add or dword add
// - 8-bit-immediate class function bits 10..8 decode; value 110 unassigned
// - three-register class bits 1..0: dword add, word add, dword sub, word sub
// - register-register class five-bit function, row bits 4..3, column 2..0
// - 64-bit-immediate class bits 10..8 decode eight dword-only operations
// - save/restore function uses bit 7: zero restore, one save
// - jump-register subclass ry decode; 011 and 111 unassigned
// - convert class ry decode for zero/sign extends; 011 and 111 unassigned
// - big-endian: first halfword bits 31..16, second bits 15..0
// - little-endian: first halfword bits 15..0, second bits 31..16
// - extended and jump-and-link forms are two halfwords in the same order
// - halfword at the program counter address is the instruction in both endians
// - uncacheable compressed fetch never exceeds one aligned word
// - uncacheable fetch may be one word or two halfwords; we use one word
// - register field 000 maps to register 16, 001 to register 17
// - register field 010 through 111 map unchanged to registers 2 through 7
// - two-operand word add: sign-extend imm8, add, keep 32 bits, sign-extend, write rx
// - two-operand word add never traps; wraps modulo two to the 32nd
// - source not a sign-extended word gives an undefined result
// - non-extensible encoding behind an extend prefix raises reserved instruction
package cifd_pkg;

  localparam int HW_W   = 16;
  localparam int WORD_W = 32;
  localparam int DW_W   = 64;
  localparam int REG_W  = 5;
  localparam int FLD_W  = 3;
  localparam int IMM8_W = 8;

  // field positions within a halfword
  localparam int MAJ_LSB        = 11;
  localparam int RX_LSB         = 8;
  localparam int RY_LSB         = 5;
  localparam int SAVE_BIT       = 7;
  localparam int RIA_BIT        = 4;
  localparam int ISA_SWITCH_BIT = 10;

  // major opcodes handled here
  localparam logic [4:0] MAJ_LINK_FORM = 5'h03;
  localparam logic [4:0] MAJ_SHIFT    = 5'h06;
  localparam logic [4:0] MAJ_RIA      = 5'h08;
  localparam logic [4:0] MAJ_ADDI8    = 5'h09;
  localparam logic [4:0] MAJ_IMM8     = 5'h0C;
  localparam logic [4:0] MAJ_THREE    = 5'h1C;
  localparam logic [4:0] MAJ_REGREG   = 5'h1D;
  localparam logic [4:0] MAJ_EXTEND   = 5'h1E;
  localparam logic [4:0] MAJ_IMM64    = 5'h1F;

  // register field translation
  localparam logic [FLD_W-1:0] XLAT_LIMIT = 3'h2;
  localparam logic [REG_W-1:0] XLAT_BASE  = 5'h10;

  // reset values
  localparam logic [1:0] RST_HW_LEFT = 2'h0;

  typedef enum logic [5:0] {
    OP_OTHER, OP_RESERVED, OP_JUMP_AND_LINK, OP_JUMP_LINK_ISA_SWITCH,
    OP_SHIFT_LEFT_LOGICAL, OP_DWORD_SHIFT_LEFT, OP_SHIFT_RIGHT_LOGICAL, OP_SHIFT_RIGHT_ARITH,
    OP_ADD_IMM_WORD3, OP_DWORD_ADD_IMM, OP_ADD_IMM_WORD,
    OP_BRANCH_T_ZERO, OP_BRANCH_T_NONZERO, OP_STORE_RA_SP, OP_ADJUST_STACK_PTR,
    OP_SAVE, OP_RESTORE, OP_COPY_TO_FULL_REG, OP_COPY_FROM_FULL_REG,
    OP_DWORD_ADD_UNSIGNED, OP_ADD_UNSIGNED_WORD, OP_DWORD_SUB_UNSIGNED, OP_SUB_UNSIGNED_WORD,
    OP_JUMP_REG_RX, OP_JUMP_REG_RA, OP_LINK_JUMP_REG,
    OP_COMPACT_JUMP_REG_RX, OP_COMPACT_JUMP_REG_RA, OP_COMPACT_LINK_JUMP_REG,
    OP_DEBUG_BREAKPOINT, OP_PRODUCT, OP_QUOTIENT, OP_REGREG_OTHER,
    OP_ZERO_EXT_BYTE, OP_ZERO_EXT_HALF, OP_ZERO_EXT_WORD,
    OP_SIGN_EXT_BYTE, OP_SIGN_EXT_HALF, OP_SIGN_EXT_WORD,
    OP_LOAD_DWORD_STACK, OP_STORE_DWORD_STACK, OP_STORE_RA_DWORD_STACK, OP_DWORD_ADJUST_STACK,
    OP_LOAD_DWORD_PCREL, OP_DWORD_ADD_IMM5, OP_DWORD_ADD_IMM_PCREL, OP_DWORD_ADD_IMM_STACK
  } cifd_op_t;

  typedef struct packed {
    cifd_op_t         op;
    logic [REG_W-1:0] rx;
    logic [REG_W-1:0] ry;
    logic             dwordOnly;
    logic             extended;
  } cifd_dec_t;

endpackage : cifd_pkg

// ---- logic/cifd_reg_xlat.sv ----
// translates a 3-bit compressed register field to a full register index
// assumes nothing; purely combinational
`timescale 1ns/10ps
module cifd_reg_xlat
  import cifd_pkg::*;
(
  // field in
  input  wire logic [FLD_W-1:0] fld,
  // register index out
  output logic      [REG_W-1:0] idx
);

  always_comb begin
    if (fld < XLAT_LIMIT) begin
      idx = XLAT_BASE | {2'h0, fld};
    end else begin
      idx = {2'h0, fld};
    end
  end

endmodule : cifd_reg_xlat

// ---- verif/cifd_decoder_test.sv ----
// self-checking bench for the compact field decoder
// assumes cifd_fetch_model supplies words and the register file
`timescale 1ns/10ps
module cifd_decoder_test
  import cifd_pkg::*;
;
  logic              clk, rst, fetchValid, fetchSkipFirst, fetchUncached, bigEndian;
  logic              fetchReady, fetchWide, decValid, rsvdExc, rfWrEn;
  logic [WORD_W-1:0] fetchData;
  cifd_dec_t         decInfo;
  logic [REG_W-1:0]  rfRdIdx, rfWrIdx;
  logic [DW_W-1:0]   rfRdData, rfWrData;
  logic [15:0]       hwQ[$];
  cifd_op_t          expQ[$];
  logic              expX[$];
  cifd_dec_t         decQ[$];
  logic              rsvQ[$];
  logic [68:0]       wrQ[$];
  int                fail_count, n_checks;
  cifd_op_t shOp[4] = '{OP_SHIFT_LEFT_LOGICAL, OP_DWORD_SHIFT_LEFT, OP_SHIFT_RIGHT_LOGICAL,
                        OP_SHIFT_RIGHT_ARITH};
  cifd_op_t thOp[4] = '{OP_DWORD_ADD_UNSIGNED, OP_ADD_UNSIGNED_WORD, OP_DWORD_SUB_UNSIGNED,
                        OP_SUB_UNSIGNED_WORD};
  cifd_op_t imm8Op[8] = '{OP_BRANCH_T_ZERO, OP_BRANCH_T_NONZERO, OP_STORE_RA_SP,
                          OP_ADJUST_STACK_PTR, OP_RESTORE, OP_COPY_TO_FULL_REG, OP_RESERVED,
                          OP_COPY_FROM_FULL_REG};
  cifd_op_t dw64Op[8] = '{OP_LOAD_DWORD_STACK, OP_STORE_DWORD_STACK, OP_STORE_RA_DWORD_STACK,
                          OP_DWORD_ADJUST_STACK, OP_LOAD_DWORD_PCREL, OP_DWORD_ADD_IMM5,
                          OP_DWORD_ADD_IMM_PCREL, OP_DWORD_ADD_IMM_STACK};
  cifd_op_t jregOp[8] = '{OP_JUMP_REG_RX, OP_JUMP_REG_RA, OP_LINK_JUMP_REG, OP_RESERVED,
                          OP_COMPACT_JUMP_REG_RX, OP_COMPACT_JUMP_REG_RA,
                          OP_COMPACT_LINK_JUMP_REG, OP_RESERVED};
  cifd_op_t cvOp[8] = '{OP_ZERO_EXT_BYTE, OP_ZERO_EXT_HALF, OP_ZERO_EXT_WORD, OP_RESERVED,
                        OP_SIGN_EXT_BYTE, OP_SIGN_EXT_HALF, OP_SIGN_EXT_WORD, OP_RESERVED};

  cifd_decoder cifd_decoder_inst (.clk(clk), .rst(rst), .fetchValid(fetchValid),
    .fetchData(fetchData), .fetchSkipFirst(fetchSkipFirst), .fetchUncached(fetchUncached),
    .bigEndian(bigEndian), .fetchReady(fetchReady), .fetchWide(fetchWide),
    .decValid(decValid), .decInfo(decInfo), .rsvdExc(rsvdExc), .rfRdIdx(rfRdIdx),
    .rfRdData(rfRdData), .rfWrEn(rfWrEn), .rfWrIdx(rfWrIdx), .rfWrData(rfWrData));

  cifd_fetch_model cifd_fetch_model_inst (.clk(clk), .rst(rst), .fetchReady(fetchReady),
    .fetchValid(fetchValid), .fetchData(fetchData), .rfRdIdx(rfRdIdx), .rfRdData(rfRdData),
    .rfWrEn(rfWrEn), .rfWrIdx(rfWrIdx), .rfWrData(rfWrData));

  always #5 clk = ~clk;

  // pulses sampled before the edge retires them
  always @(posedge clk) begin
    if (rst === 1'h0) begin
      if (decValid === 1'h1) begin
        decQ.push_back(decInfo);
        rsvQ.push_back(rsvdExc);
      end
      if (rfWrEn === 1'h1) wrQ.push_back({rfWrIdx, rfWrData});
    end
  end

  task automatic chk_op(input string what, input cifd_op_t e, input cifd_op_t g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %s seen %s", what, e.name(), g.name());
    end
  endtask : chk_op

  task automatic chk_bits(input string what, input logic [68:0] e, input logic [68:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask : chk_bits

  task automatic add(input logic [15:0] h, input cifd_op_t op);
    hwQ.push_back(h);
    expQ.push_back(op);
    expX.push_back(1'h0);
  endtask : add

  // prefix plus follower give one decode
  task automatic add2(input logic [15:0] p, input logic [15:0] h, input cifd_op_t op,
                      input logic ext);
    hwQ.push_back(p);
    hwQ.push_back(h);
    expQ.push_back(op);
    expX.push_back(ext);
  endtask : add2

  // packs halfwords by endianness, streams them, compares every decode in order
  task automatic run_stream(input logic big);
    logic [15:0] a, b;
    int          n;
    decQ.delete();
    rsvQ.delete();
    if (hwQ.size() % 2) add(16'h0000, OP_OTHER);
    bigEndian = big;
    for (int i = 0; i < hwQ.size(); i += 2) begin
      a = hwQ[i];
      b = hwQ[i+1];
      cifd_fetch_model_inst.push(big ? {a, b} : {b, a});
    end
    n = 0;
    while (decQ.size() < expQ.size() && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    repeat (4) @(posedge clk);
    #1;
    chk_bits("decode count", 69'(expQ.size()), 69'(decQ.size()));
    for (int i = 0; i < expQ.size() && i < decQ.size(); i++) begin
      chk_op("op", expQ[i], decQ[i].op);
      chk_bits("reserved flag", 69'(expQ[i] == OP_RESERVED), 69'(rsvQ[i]));
      chk_bits("extended flag", 69'(expX[i]), 69'(decQ[i].extended));
      // 64-bit-only: the dword forms of each class and the whole imm64 class
      chk_bits("dword only", 69'((expQ[i] inside {OP_DWORD_SHIFT_LEFT, OP_DWORD_ADD_IMM,
        OP_DWORD_ADD_UNSIGNED, OP_DWORD_SUB_UNSIGNED, OP_ZERO_EXT_WORD, OP_SIGN_EXT_WORD})
        || expQ[i] >= OP_LOAD_DWORD_STACK), 69'(decQ[i].dwordOnly));
    end
    hwQ.delete();
    expQ.delete();
    expX.delete();
  endtask : run_stream

  task automatic test_classes(input logic big);
    for (int i = 0; i < 8; i++) begin
      if (i < 4) begin
        add({MAJ_SHIFT, 9'h000, 2'(i)}, shOp[i]);
        add({MAJ_THREE, 9'h000, 2'(i)}, thOp[i]);
      end
      add({MAJ_IMM8, 3'(i), 8'h00}, imm8Op[i]);
      add({MAJ_IMM64, 3'(i), 8'h00}, dw64Op[i]);
      add({MAJ_REGREG, 3'h0, 3'(i), 5'h00}, jregOp[i]);
      add({MAJ_REGREG, 3'h0, 3'(i), 5'h11}, cvOp[i]);
    end
    add({MAJ_RIA, 6'h00, 1'h0, 4'h0}, OP_ADD_IMM_WORD3);
    add({MAJ_RIA, 6'h00, 1'h1, 4'h0}, OP_DWORD_ADD_IMM);
    add({MAJ_IMM8, 3'h4, 8'h80}, OP_SAVE);
    add({MAJ_REGREG, 6'h00, 5'h01}, OP_DEBUG_BREAKPOINT);
    add({MAJ_REGREG, 6'h00, 5'h18}, OP_PRODUCT);
    add({MAJ_REGREG, 6'h00, 5'h1A}, OP_QUOTIENT);
    add({MAJ_REGREG, 6'h00, 5'h09}, OP_RESERVED);
    run_stream(big);
    $display("test classes done, big endian %0d", big);
  endtask : test_classes

  // first prefix straddles a word boundary
  task automatic test_prefix;
    add({MAJ_SHIFT, 11'h000}, OP_SHIFT_LEFT_LOGICAL);
    add2({MAJ_LINK_FORM, 11'h000}, 16'h1234, OP_JUMP_AND_LINK, 1'h0);
    add2({MAJ_LINK_FORM, 11'h400}, 16'h5678, OP_JUMP_LINK_ISA_SWITCH, 1'h0);
    add2({MAJ_EXTEND, 11'h000}, {MAJ_RIA, 11'h000}, OP_ADD_IMM_WORD3, 1'h1);
    add2({MAJ_EXTEND, 11'h000}, {MAJ_THREE, 11'h001}, OP_RESERVED, 1'h1);
    add2({MAJ_EXTEND, 11'h000}, {MAJ_IMM8, 3'h3, 8'h00}, OP_ADJUST_STACK_PTR, 1'h1);
    add2({MAJ_EXTEND, 11'h000}, {MAJ_IMM8, 3'h5, 8'h00}, OP_RESERVED, 1'h1);
    run_stream(1'h0);
    $display("test prefix done");
  endtask : test_prefix

  task automatic test_add;
    logic [2:0]  rx[4]  = '{3'h0, 3'h1, 3'h2, 3'h7};
    logic [7:0]  imm[4] = '{8'h01, 8'h01, 8'hFF, 8'h80};
    logic [63:0] v[4]   = '{64'h000000007FFFFFFF, 64'hFFFFFFFFFFFFFFFF, 64'h5,
                            64'hFFFFFFFF80000000};
    logic [31:0] s;
    logic [4:0]  idx;
    wrQ.delete();
    for (int i = 0; i < 4; i++) begin
      cifd_fetch_model_inst.regs[rx[i] < 3'h2 ? 5'(rx[i]) + 5'h10 : 5'(rx[i])] = v[i];
      add({MAJ_ADDI8, rx[i], imm[i]}, OP_ADD_IMM_WORD);
    end
    run_stream(1'h1);
    chk_bits("write count", 69'h4, 69'(wrQ.size()));
    for (int i = 0; i < 4 && i < wrQ.size(); i++) begin
      s   = v[i][31:0] + {{24{imm[i][7]}}, imm[i]};
      idx = rx[i] < 3'h2 ? 5'(rx[i]) + 5'h10 : 5'(rx[i]);
      chk_bits("write", {idx, {32{s[31]}}, s}, wrQ[i]);
    end
    $display("test add done");
  endtask : test_add

  // only the higher-address halfword of each word may decode
  task automatic test_skip(input logic big);
    fetchSkipFirst = 1'h1;
    hwQ.push_back({MAJ_IMM8, 3'h6, 8'h00});
    add({MAJ_SHIFT, 11'h003}, OP_SHIFT_RIGHT_ARITH);
    hwQ.push_back({MAJ_IMM8, 3'h6, 8'h00});
    add({MAJ_IMM64, 11'h000}, OP_LOAD_DWORD_STACK);
    run_stream(big);
    fetchSkipFirst = 1'h0;
    $display("test skip done, big endian %0d", big);
  endtask : test_skip

  task automatic test_uncached;
    fetchUncached = 1'h1;
    #1;
    chk_bits("fetch wide", 69'h0, 69'(fetchWide));
    add({MAJ_SHIFT, 11'h003}, OP_SHIFT_RIGHT_ARITH);
    add({MAJ_SHIFT, 11'h002}, OP_SHIFT_RIGHT_LOGICAL);
    run_stream(1'h1);
    fetchUncached = 1'h0;
    #1;
    chk_bits("fetch wide", 69'h1, 69'(fetchWide));
    $display("test uncached done");
  endtask : test_uncached

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test

  // whole run needs about two hundred cycles
  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end

  initial begin
    clk            = 1'h0;
    rst            = 1'h1;
    fetchSkipFirst = 1'h0;
    fetchUncached  = 1'h0;
    bigEndian      = 1'h1;
    fail_count     = 0;
    n_checks       = 0;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'h0;
    test_classes(1'h1);
    test_classes(1'h0);
    test_prefix();
    test_skip(1'h1);
    test_skip(1'h0);
    test_add();
    test_uncached();
    end_of_test();
  end
endmodule : cifd_decoder_test

// ---- verif/cifd_fetch_model.sv ----
// fetch path and integer register file facing the compact field decoder
// assumes the bench pushes aligned words already packed for the active endianness
`timescale 1ns/10ps
module cifd_fetch_model
  import cifd_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // fetch side
  input  wire logic              fetchReady,
  output logic                   fetchValid,
  output logic      [WORD_W-1:0] fetchData,
  // register file
  input  wire logic [REG_W-1:0]  rfRdIdx,
  output logic      [DW_W-1:0]   rfRdData,
  input  wire logic              rfWrEn,
  input  wire logic [REG_W-1:0]  rfWrIdx,
  input  wire logic [DW_W-1:0]   rfWrData
);
  logic [WORD_W-1:0] wordQ[$];
  logic [DW_W-1:0]   regs[32];
  logic              taken;

  initial begin
    fetchValid = 1'h0;
    fetchData  = 32'hA5A55A5A;
    foreach (regs[i]) regs[i] = 64'h0;
  end

  assign rfRdData = regs[rfRdIdx];

  task automatic push(input logic [WORD_W-1:0] w);
    wordQ.push_back(w);
  endtask : push

  // word held until taken; idle data inverted so a stale word never looks fresh
  always @(posedge clk) begin
    taken = fetchValid && fetchReady && !rst;
    if (rfWrEn === 1'h1) regs[rfWrIdx] <= rfWrData;
    #1;
    if (taken) void'(wordQ.pop_front());
    fetchValid = (wordQ.size() != 0) && !rst;
    fetchData  = fetchValid ? wordQ[0] : ~fetchData;
  end
endmodule : cifd_fetch_model
